// *** rtl/rcp_top.sv ***
// Rail control pin logic: enable and sleep inputs, general outputs, interrupt line.
`timescale 1ns/1ns
module rcp_top
   import rcp_pkg::*;
#(
   parameter int P_NUM_RAILS = NUM_RAILS
)
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Enable and sleep inputs from the host.
   input wire logic [NUM_CTL-1:0] i_rail_enable_in,
   // Power-good status from the regulators.
   input wire logic [NUM_RAILS-1:0] i_rail_pg,
   // Register port.
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Regulator controls.
   output logic [NUM_RAILS-1:0] o_rail_on,
   output logic [NUM_RAILS-1:0] o_rail_sleep,
   output logic [NUM_RAILS*VSEL_W-1:0] o_rail_vsel,
   // General output pins, drive level and enable.
   output logic [NUM_GPO-1:0] o_general_out,
   output logic [NUM_GPO-1:0] o_general_out_oe,
   // Open-drain interrupt pin.
   output logic o_interrupt_out_n,
   output logic o_interrupt_out_n_oe
);
   // Index of the enable inputs that double as sleep controls.
   localparam int CTL_SLP_A = 2;
   localparam int CTL_SLP_B = 5;
   localparam int VREG_W = 5;
   localparam int RIDX_W = $clog2(NUM_RAILS);  // Rail index bits of a voltage code address.
   // The sleep code block is as long as the normal one; anything above it is unmapped.
   localparam logic [ADDR_W-1:0] VSLP_END = REG_VSLP_BASE + (REG_VSLP_BASE - REG_VNORM_BASE);

   // Configuration registers.
   logic [NUM_RAILS-1:0] assign_q [NUM_CTL];  // Rail group per enable input.
   logic [NUM_RAILS-1:0] assign_d [NUM_CTL];
   logic [DATA_W-1:0] slp_cfg_q;               // Sleep selects and groups.
   logic [DATA_W-1:0] slp_cfg_d;
   logic [DATA_W-1:0] gpo_src_q;               // Power-good masks.
   logic [DATA_W-1:0] gpo_src_d;
   logic [DATA_W-1:0] gpo_ctl_q;               // Mode, driver, host bits.
   logic [DATA_W-1:0] gpo_ctl_d;
   logic [VSEL_W-1:0] vnorm_q [NUM_RAILS];     // Normal voltage codes.
   logic [VSEL_W-1:0] vnorm_d [NUM_RAILS];
   logic [VSEL_W-1:0] vslp_q [NUM_RAILS];      // Sleep voltage codes.
   logic [VSEL_W-1:0] vslp_d [NUM_RAILS];
   logic [IRQ_W-1:0] irq_stat_q;               // Sticky events.
   logic [IRQ_W-1:0] irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_q;               // Event enables.
   logic [IRQ_W-1:0] irq_mask_d;
   // Input history for edge events.
   logic [NUM_CTL-1:0] ctl_prev_q;
   logic [NUM_CTL-1:0] ctl_prev_d;
   logic [NUM_RAILS-1:0] pg_prev_q;
   logic [NUM_RAILS-1:0] pg_prev_d;
   // Registered outputs.
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [NUM_RAILS-1:0] on_q;
   logic [NUM_RAILS-1:0] on_d;
   logic [NUM_RAILS-1:0] sleep_q;
   logic [NUM_RAILS-1:0] sleep_d;
   logic [NUM_RAILS*VSEL_W-1:0] vsel_q;
   logic [NUM_RAILS*VSEL_W-1:0] vsel_d;
   logic [NUM_GPO-1:0] gpo_lvl_q;
   logic [NUM_GPO-1:0] gpo_lvl_d;
   logic [NUM_GPO-1:0] gpo_oe_q;
   logic [NUM_GPO-1:0] gpo_oe_d;
   logic irq_oe_q;
   logic irq_oe_d;
   // Decode helpers.
   logic [VREG_W-1:0] word_idx;
   logic [RIDX_W-1:0] rail_idx;

   // Driver submodule link.
   rcp_gpo_if gpo_bus ();

   // Registers sit on word boundaries; the group and voltage code blocks ignore the two lowest address bits.
   assign word_idx = i_addr[VREG_W+1:2];
   assign rail_idx = i_addr[RIDX_W+1:2];

   // Register writes and sticky interrupt status.
   always_comb
   begin
      logic [IRQ_W-1:0] ev;
      ev = '0;
      assign_d = assign_q;
      slp_cfg_d = slp_cfg_q;
      gpo_src_d = gpo_src_q;
      gpo_ctl_d = gpo_ctl_q;
      vnorm_d = vnorm_q;
      vslp_d = vslp_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      ctl_prev_d = i_rail_enable_in;
      pg_prev_d = i_rail_pg;
      if (i_wr)
      begin
         // Plain configuration writes.
         if (i_addr < REG_SLEEP_CFG)
         begin
            assign_d[word_idx[2:0]] = i_wdata[NUM_RAILS-1:0];
         end
         else if (i_addr == REG_SLEEP_CFG)
         begin
            slp_cfg_d = i_wdata;
         end
         else if (i_addr == REG_GPO_SRC)
         begin
            gpo_src_d = i_wdata;
         end
         else if (i_addr == REG_GPO_CTL)
         begin
            gpo_ctl_d = i_wdata;
         end
         else if (i_addr == REG_IRQ_STAT)
         begin
            irq_stat_d = irq_stat_q & ~i_wdata[IRQ_W-1:0];
         end
         else if (i_addr == REG_IRQ_MASK)
         begin
            irq_mask_d = i_wdata[IRQ_W-1:0];
         end
         else if ((i_addr >= REG_VNORM_BASE) && (i_addr < REG_VSLP_BASE))
         begin
            vnorm_d[rail_idx] = i_wdata[VSEL_W-1:0];
         end
         else if ((i_addr >= REG_VSLP_BASE) && (i_addr < VSLP_END))
         begin
            vslp_d[rail_idx] = i_wdata[VSEL_W-1:0];
         end
         else
         begin
            // Unmapped writes are dropped.
            irq_mask_d = irq_mask_q;
         end
      end
      // Events: any enable input edge, and any rail losing power-good.
      ev[NUM_CTL-1:0] = i_rail_enable_in ^ ctl_prev_q;
      ev[IRQ_W-1:NUM_CTL] = pg_prev_q & ~i_rail_pg;
      // Setting is applied after the clear, so a new event survives it.
      irq_stat_d = irq_stat_d | ev;
   end

   // Rail enable, sleep and voltage selection.
   always_comb
   begin
      logic slp_a;
      logic slp_b;
      slp_a = slp_cfg_q[SLP_SEL_A_BIT];
      slp_b = slp_cfg_q[SLP_SEL_B_BIT];
      on_d = '0;
      sleep_d = '0;
      for (int c = 0; c < NUM_CTL; c++)
      begin
         // Inputs in sleep mode take no part in enabling.
         if (!((c == CTL_SLP_A) && slp_a) && !((c == CTL_SLP_B) && slp_b))
         begin
            // A high input turns its whole group on; a low input turns nothing on.
            if (i_rail_enable_in[c])
            begin
               on_d = on_d | assign_q[c];
            end
         end
      end
      // Low level on a sleep-configured input sleeps its group.
      if (slp_a && !i_rail_enable_in[CTL_SLP_A])
      begin
         sleep_d = sleep_d | slp_cfg_q[SLP_MAP_A_LSB +: NUM_RAILS];
      end
      if (slp_b && !i_rail_enable_in[CTL_SLP_B])
      begin
         sleep_d = sleep_d | slp_cfg_q[SLP_MAP_B_LSB +: NUM_RAILS];
      end
      // Each rail takes its sleep code while sleeping.
      for (int r = 0; r < NUM_RAILS; r++)
      begin
         vsel_d[r*VSEL_W +: VSEL_W] = sleep_d[r] ? vslp_q[r] : vnorm_q[r];
      end
   end

   // Read data, valid only in the cycle after the strobe.
   always_comb
   begin
      rdata_d = RST_ZERO;
      if (i_rd)
      begin
         if (i_addr < REG_SLEEP_CFG)
         begin
            rdata_d[NUM_RAILS-1:0] = assign_q[word_idx[2:0]];
         end
         else if (i_addr == REG_SLEEP_CFG)
         begin
            rdata_d = slp_cfg_q;
         end
         else if (i_addr == REG_GPO_SRC)
         begin
            rdata_d = gpo_src_q;
         end
         else if (i_addr == REG_GPO_CTL)
         begin
            rdata_d = gpo_ctl_q;
         end
         else if (i_addr == REG_RAIL_STAT)
         begin
            rdata_d[STAT_EN_LSB +: NUM_RAILS] = on_q;
            rdata_d[STAT_SLP_LSB +: NUM_RAILS] = sleep_q;
            rdata_d[STAT_PG_LSB +: NUM_RAILS] = i_rail_pg;
         end
         else if (i_addr == REG_IRQ_STAT)
         begin
            rdata_d[IRQ_W-1:0] = irq_stat_q;
         end
         else if (i_addr == REG_IRQ_MASK)
         begin
            rdata_d[IRQ_W-1:0] = irq_mask_q;
         end
         else if ((i_addr >= REG_VNORM_BASE) && (i_addr < REG_VSLP_BASE))
         begin
            rdata_d[VSEL_W-1:0] = vnorm_q[rail_idx];
         end
         else if ((i_addr >= REG_VSLP_BASE) && (i_addr < VSLP_END))
         begin
            rdata_d[VSEL_W-1:0] = vslp_q[rail_idx];
         end
         else
         begin
            // Unmapped addresses read as zero.
            rdata_d = RST_ZERO;
         end
      end
      // Interrupt pin pulled low while a flag is pending and unmasked.
      irq_oe_d = |(irq_stat_d & irq_mask_d);
   end

   // Feed the output driver; combined power-good is all chosen rails good.
   genvar g;
   generate
      for (g = 0; g < NUM_GPO; g++)
      begin : g_pg
         logic [NUM_RAILS-1:0] sel;
         assign sel = gpo_src_q[g*NUM_RAILS +: NUM_RAILS];
         // A rail outside the selection can never pull the combined status down.
         // Empty selection reads as not good.
         assign gpo_bus.pg_hit[g] = (|sel) && ((sel & i_rail_pg) == sel);
      end
   endgenerate
   assign gpo_bus.mode_host = gpo_ctl_q[GPO_MODE_LSB +: NUM_GPO];
   assign gpo_bus.push_pull = gpo_ctl_q[GPO_PP_LSB +: NUM_GPO];
   assign gpo_bus.host_bit = gpo_ctl_q[GPO_HOST_LSB +: NUM_GPO];

   rcp_gpo_drv u_drv (
      .gpo (gpo_bus.drv)
   );

   // Next general output drive, taken from the driver submodule.
   always_comb
   begin
      gpo_lvl_d = gpo_bus.pin_level;
      gpo_oe_d = gpo_bus.pin_oe;
   end

   // State and output registers.
   // Reset clears all configuration, so every rail starts off and the interrupt line is released.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int c = 0; c < NUM_CTL; c++)
         begin
            assign_q[c] <= '0;
         end
         for (int r = 0; r < NUM_RAILS; r++)
         begin
            vnorm_q[r] <= RST_VSEL;
            vslp_q[r] <= RST_VSEL;
         end
         slp_cfg_q <= RST_ZERO;
         gpo_src_q <= RST_ZERO;
         gpo_ctl_q <= RST_ZERO;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         ctl_prev_q <= '0;
         pg_prev_q <= '0;
         rdata_q <= RST_ZERO;
         on_q <= '0;
         sleep_q <= '0;
         vsel_q <= '0;
         gpo_lvl_q <= '0;
         gpo_oe_q <= '0;
         irq_oe_q <= 1'b0;
      end
      else
      begin
         assign_q <= assign_d;
         vnorm_q <= vnorm_d;
         vslp_q <= vslp_d;
         slp_cfg_q <= slp_cfg_d;
         gpo_src_q <= gpo_src_d;
         gpo_ctl_q <= gpo_ctl_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         ctl_prev_q <= ctl_prev_d;
         pg_prev_q <= pg_prev_d;
         rdata_q <= rdata_d;
         on_q <= on_d;
         sleep_q <= sleep_d;
         vsel_q <= vsel_d;
         gpo_lvl_q <= gpo_lvl_d;
         gpo_oe_q <= gpo_oe_d;
         irq_oe_q <= irq_oe_d;
      end
   end

   // Outputs straight from flip-flops.
   assign o_rdata = rdata_q;
   assign o_rail_on = on_q;
   assign o_rail_sleep = sleep_q;
   assign o_rail_vsel = vsel_q;
   assign o_general_out = gpo_lvl_q;
   assign o_general_out_oe = gpo_oe_q;
   // The interrupt pin never drives high, only pulls low.
   assign o_interrupt_out_n = 1'b0;
   assign o_interrupt_out_n_oe = irq_oe_q;
endmodule

// *** rtl/rcp_pkg.sv ***
// Package with register map, field layouts and constants of the rail control pin logic.
package rcp_pkg;
   // Geometry.
   localparam int NUM_CTL = 6;
   localparam int NUM_RAILS = 8;
   localparam int NUM_GPO = 4;
   localparam int VSEL_W = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte addresses.
   localparam logic [7:0] REG_ASSIGN_BASE = 8'h00;  // Six rail-group maps, one per enable input.
   localparam logic [7:0] REG_SLEEP_CFG = 8'h18;    // Sleep mode selects and sleep group maps.
   localparam logic [7:0] REG_GPO_SRC = 8'h1C;      // Power-good source masks, one byte per output.
   localparam logic [7:0] REG_GPO_CTL = 8'h20;      // Mode, driver type and host bits.
   localparam logic [7:0] REG_RAIL_STAT = 8'h24;    // Live rail enable, sleep and power-good.
   localparam logic [7:0] REG_IRQ_STAT = 8'h28;     // Sticky events, write one to clear.
   localparam logic [7:0] REG_IRQ_MASK = 8'h2C;     // Interrupt enable per event.
   localparam logic [7:0] REG_VNORM_BASE = 8'h40;   // Normal voltage code per rail.
   localparam logic [7:0] REG_VSLP_BASE = 8'h60;    // Sleep voltage code per rail.
   // Field positions in the sleep configuration register.
   localparam int SLP_SEL_A_BIT = 0;
   localparam int SLP_SEL_B_BIT = 1;
   localparam int SLP_MAP_A_LSB = 8;
   localparam int SLP_MAP_B_LSB = 16;
   // Field positions in the general output control register.
   localparam int GPO_MODE_LSB = 0;   // 1 = follow host bit, 0 = follow power-good.
   localparam int GPO_PP_LSB = 4;     // 1 = push-pull except on output four, 0 = open-drain.
   localparam int GPO_HOST_LSB = 8;   // Host-written output levels.
   // Rail status fields.
   localparam int STAT_EN_LSB = 0;
   localparam int STAT_SLP_LSB = 8;
   localparam int STAT_PG_LSB = 16;
   // Interrupt event layout: enable input edges, then power-good falls.
   localparam int IRQ_W = NUM_CTL + NUM_RAILS;
   // Reset values.
   localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
   localparam logic [VSEL_W-1:0] RST_VSEL = 8'h00;
endpackage

// *** rtl/rcp_gpo_if.sv ***
// Interface carrying the general output configuration and pin drive between modules.
`timescale 1ns/1ns
interface rcp_gpo_if;
   import rcp_pkg::*;
   logic [NUM_GPO-1:0] mode_host;   // Output follows host bit.
   logic [NUM_GPO-1:0] push_pull;   // Driver type per output.
   logic [NUM_GPO-1:0] host_bit;    // Host-written level.
   logic [NUM_GPO-1:0] pg_hit;      // Combined power-good of chosen rails.
   logic [NUM_GPO-1:0] pin_level;   // Level presented when driving.
   logic [NUM_GPO-1:0] pin_oe;      // Pin drive enable.
   modport ctrl (output mode_host, push_pull, host_bit, pg_hit, input pin_level, pin_oe);
   modport drv (input mode_host, push_pull, host_bit, pg_hit, output pin_level, pin_oe);
endinterface

// *** rtl/rcp_gpo_drv.sv ***
// General output driver: source select and open-drain or push-pull drive per output.
`timescale 1ns/1ns
module rcp_gpo_drv
   import rcp_pkg::*;
(
   // Configuration and pin drive.
   rcp_gpo_if.drv gpo
);
   // Last output has no push-pull driver.
   localparam int LAST = NUM_GPO - 1;

   genvar g;
   generate
      for (g = 0; g < NUM_GPO; g++)
      begin : g_out
         logic want;
         logic pp;
         // Each output picks power-good or the host bit.
         assign want = gpo.mode_host[g] ? gpo.host_bit[g] : gpo.pg_hit[g];
         // Outputs one to three choose their driver type; the fourth is forced open-drain.
         assign pp = (g == LAST) ? 1'b0 : gpo.push_pull[g];
         // Open-drain drives only a low; push-pull always drives the level.
         assign gpo.pin_level[g] = pp ? want : 1'b0;
         assign gpo.pin_oe[g] = pp ? 1'b1 : ~want;
      end
   endgenerate
endmodule

// *** test/rcp_top_monitor.sv ***
// Checker watching the rail control pin logic at its top-level ports.
`timescale 1ns/1ns
module rcp_top_monitor
   import rcp_pkg::*;
#(
   parameter int P_NUM_RAILS = NUM_RAILS
)
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Inputs of the design.
   input wire logic [NUM_CTL-1:0] i_rail_enable_in,
   input wire logic [NUM_RAILS-1:0] i_rail_pg,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   // Outputs of the design.
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic [NUM_RAILS-1:0] o_rail_on,
   input wire logic [NUM_RAILS-1:0] o_rail_sleep,
   input wire logic [NUM_RAILS*VSEL_W-1:0] o_rail_vsel,
   input wire logic [NUM_GPO-1:0] o_general_out,
   input wire logic [NUM_GPO-1:0] o_general_out_oe,
   input wire logic o_interrupt_out_n,
   input wire logic o_interrupt_out_n_oe
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // Only these writes may release a pending interrupt.
   wire logic irq_wr = i_wr && (i_addr == REG_IRQ_STAT || i_addr == REG_IRQ_MASK);
   // Line held low and nobody clearing or masking.
   sequence s_irq_quiet;
      o_interrupt_out_n_oe && !irq_wr;
   endsequence
   // Three cycles with no write and steady enable inputs, long enough to cover the pipeline.
   sequence s_calm;
      (!i_wr && $stable(i_rail_enable_in)) [*3];
   endsequence
   // Same for the power-good side feeding the general outputs.
   sequence s_pg_calm;
      (!i_wr && $stable(i_rail_pg)) [*3];
   endsequence
   a_irq_never_high: assert property (o_interrupt_out_n == 1'b0) else $error("interrupt pin driven high");
   a_irq_hold_pending: assert property (s_irq_quiet |=> o_interrupt_out_n_oe) else $error("interrupt released");
   a_general_out_4_open_drain: assert property (o_general_out[3] == 1'b0) else $error("output four driven high");
   a_gpo_drive_kind: assert property ((o_general_out & ~o_general_out_oe) == 4'h0) else $error("high level undriven");
   a_rail_on_steady: assert property (s_calm |=> $stable(o_rail_on)) else $error("rail enable moved alone");
   a_sleep_steady: assert property (s_calm |=> $stable(o_rail_sleep)) else $error("sleep moved alone");
   a_vsel_steady: assert property (s_calm |=> $stable(o_rail_vsel)) else $error("voltage code moved alone");
   a_rails_need_input: assert property ((i_rail_enable_in == 6'h00) [*2] |=> o_rail_on == 8'h00)
      else $error("rail on with all inputs low");
   a_sleep_needs_low: assert property ((i_rail_enable_in[2] && i_rail_enable_in[5]) [*2] |=> o_rail_sleep == 8'h00)
      else $error("sleep with sleep inputs high");
   a_gpo_steady: assert property (s_pg_calm |=> $stable(o_general_out) && $stable(o_general_out_oe))
      else $error("general output moved alone");
   a_rdata_one_cycle: assert property (!i_rd |=> o_rdata == 32'h0000_0000) else $error("read data without read");
endmodule
bind rcp_top rcp_top_monitor #(.P_NUM_RAILS(P_NUM_RAILS)) u_rcp_top_monitor (.i_clk(i_clk), .i_rst(i_rst),
   .i_rail_enable_in(i_rail_enable_in), .i_rail_pg(i_rail_pg), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_rail_on(o_rail_on), .o_rail_sleep(o_rail_sleep), .o_rail_vsel(o_rail_vsel),
   .o_general_out(o_general_out), .o_general_out_oe(o_general_out_oe), .o_interrupt_out_n(o_interrupt_out_n),
   .o_interrupt_out_n_oe(o_interrupt_out_n_oe));

// *** test/rcp_host_model.sv ***
// Host board model: pull-ups and receivers on the general outputs and the interrupt line.
`timescale 1ns/1ns
module rcp_host_model
   import rcp_pkg::*;
(
   // Pin drive from the device.
   input wire logic [NUM_GPO-1:0] i_general_out,
   input wire logic [NUM_GPO-1:0] i_general_out_oe,
   input wire logic i_interrupt_out_n,
   input wire logic i_interrupt_out_n_oe,
   // Levels as the host sees them.
   output logic [NUM_GPO-1:0] o_gpo_pin,
   output logic o_irq_pin
);
   // A released pin floats up to the board pull-up, so a stale level can never be read.
   always_comb
   begin
      for (int g = 0; g < NUM_GPO; g++)
         o_gpo_pin[g] = i_general_out_oe[g] ? i_general_out[g] : 1'b1;
      o_irq_pin = i_interrupt_out_n_oe ? i_interrupt_out_n : 1'b1;
   end
endmodule

// *** test/tb.sv ***
// Self-checking testbench of the rail control pin logic.
`timescale 1ns/1ns
module tb;
   import rcp_pkg::*;
   logic i_clk, i_rst, i_wr, i_rd;
   logic [NUM_CTL-1:0] en;
   logic [NUM_RAILS-1:0] pg, o_rail_on, o_rail_sleep, grp;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, o_rdata, r, src, ctl, lfsr_q;
   logic [NUM_RAILS*VSEL_W-1:0] o_rail_vsel;
   logic [NUM_GPO-1:0] gpo, gpo_oe, gpo_pin;
   logic [7:0] e, vn[NUM_RAILS], vs[NUM_RAILS];
   logic irq_n, irq_oe, irq_pin;
   int n_errors = 0;
   int compares = 0;
   rcp_top u_rcp_top (.i_clk(i_clk), .i_rst(i_rst), .i_rail_enable_in(en), .i_rail_pg(pg), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rail_on(o_rail_on),
      .o_rail_sleep(o_rail_sleep), .o_rail_vsel(o_rail_vsel), .o_general_out(gpo), .o_general_out_oe(gpo_oe),
      .o_interrupt_out_n(irq_n), .o_interrupt_out_n_oe(irq_oe));
   rcp_host_model u_rcp_host_model (.i_general_out(gpo), .i_general_out_oe(gpo_oe), .i_interrupt_out_n(irq_n),
      .i_interrupt_out_n_oe(irq_oe), .o_gpo_pin(gpo_pin), .o_irq_pin(irq_pin));
   // Free-running 100 MHz clock.
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Fixed-seed generator so every run repeats.
   function automatic void rnd(output logic [31:0] v);
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      v = lfsr_q;
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One-cycle write strobe; the strobe drops at the next edge so calls never collide.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   // Read data is looked at only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   task automatic drive(input logic [5:0] e6, input logic [7:0] p);
      @(posedge i_clk);
      en <= e6;
      pg <= p;
   endtask
   // Wait past the register stage, then look once outputs have settled.
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Sleeping rails take their sleep code, all others the normal code.
   function automatic logic [63:0] vsel_exp(input logic [7:0] s);
      for (int k = 0; k < NUM_RAILS; k++)
         vsel_exp[k*8 +: 8] = s[k] ? vs[k] : vn[k];
   endfunction
   // Returns drive enables in the upper nibble and levels in the lower nibble.
   function automatic logic [7:0] gpo_exp(input logic [31:0] s, input logic [31:0] c, input logic [7:0] p);
      logic val, pp;
      for (int g = 0; g < NUM_GPO; g++)
      begin
         // All chosen rails must be good; an empty choice reads as not good.
         val = c[g] ? c[8+g] : (|s[g*8 +: 8] && ((s[g*8 +: 8] & p) == s[g*8 +: 8]));
         pp = c[4+g] && g != 3;
         gpo_exp[g] = pp & val;
         gpo_exp[4+g] = pp | ~val;
      end
   endfunction
   // Hang guard: a stuck run counts as a mismatch.
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      lfsr_q = 32'h457B;
      i_rst = 1'b1;
      {i_wr, i_rd, en, pg, i_addr, i_wdata} = '0;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(REG_RAIL_STAT, 32'h0);
      rd(8'hFC, 32'h0);
      chk(irq_pin, 1'b1);
      // Every enable input switches its own random group on and off.
      for (int k = 0; k < NUM_CTL; k++)
      begin
         rnd(r);
         wr(REG_ASSIGN_BASE + 8'(4*k), {24'h0, r[7:0]});
         drive(6'(1 << k), 8'h00);
         step(2);
         chk(o_rail_on, r[7:0]);
         drive(6'h00, 8'h00);
         step(2);
         chk(o_rail_on, 8'h00);
         wr(REG_ASSIGN_BASE + 8'(4*k), 32'h0);
      end
      for (int k = 0; k < NUM_RAILS; k++)
      begin
         rnd(r);
         vn[k] = r[7:0];
         vs[k] = r[15:8];
         wr(REG_VNORM_BASE + 8'(4*k), {24'h0, vn[k]});
         wr(REG_VSLP_BASE + 8'(4*k), {24'h0, vs[k]});
      end
      // Unmapped address above the sleep codes must not alias the last one.
      rd(8'hFC, 32'h0);
      wr(REG_ASSIGN_BASE, 32'hFF);
      // Both sleep inputs in turn: high keeps normal state, low sleeps the chosen group.
      for (int j = 0; j < 2; j++)
      begin
         rnd(r);
         grp = r[7:0];
         wr(REG_SLEEP_CFG, j ? {8'h0, grp, 16'h0002} : {16'h0, grp, 8'h01});
         drive(6'h25, 8'h00);
         step(3);
         chk(o_rail_sleep, 8'h00);
         chk(o_rail_vsel, vsel_exp(8'h00));
         drive(j ? 6'h05 : 6'h21, 8'h00);
         step(3);
         chk(o_rail_sleep, grp);
         chk(o_rail_on, 8'hFF);
         chk(o_rail_vsel, vsel_exp(grp));
      end
      wr(REG_SLEEP_CFG, 32'h0);
      // First pass selects push-pull on all four outputs (the fourth stays open-drain), second has all rails good, the rest are random.
      for (int i = 0; i < 5; i++)
      begin
         rnd(src);
         rnd(ctl);
         if (i == 0)
            ctl = 32'h0000_0FFF;
         // Every output on power-good so a non-empty choice reads good.
         if (i == 1)
            ctl = ctl & 32'hFFFF_FFF0;
         wr(REG_GPO_SRC, src);
         wr(REG_GPO_CTL, ctl);
         drive(6'h00, (i == 1) ? 8'hFF : src[31:24] ^ ctl[23:16]);
         step(3);
         e = gpo_exp(src, ctl, pg);
         chk(gpo, e[3:0]);
         chk(gpo_oe, e[7:4]);
         chk(gpo_pin, 4'(e[3:0] | ~e[7:4]));
      end
      // Interrupt: masked event, unmasking, two flags, cleared one by one.
      drive(6'h00, 8'hFF);
      wr(REG_IRQ_MASK, 32'h0);
      wr(REG_IRQ_STAT, 32'hFFFF_FFFF);
      step(2);
      chk(irq_oe, 1'b0);
      drive(6'h01, 8'hFF);
      step(3);
      chk(irq_oe, 1'b0);
      rd(REG_IRQ_STAT, 32'h1);
      wr(REG_IRQ_MASK, 32'h41);
      step(2);
      chk(irq_oe, 1'b1);
      chk(irq_pin, 1'b0);
      drive(6'h01, 8'hFE);
      step(3);
      rd(REG_IRQ_STAT, 32'h41);
      wr(REG_IRQ_STAT, 32'h1);
      step(2);
      chk(irq_oe, 1'b1);
      wr(REG_IRQ_STAT, 32'h40);
      step(2);
      chk(irq_oe, 1'b0);
      chk(irq_pin, 1'b1);
      report_and_stop();
   end
endmodule
